// ---- rtl/fbc_host.sv ----
// Host controller that issues command sequences to a multi-bank flash.
// Functional notes
// R1: Wrong or out-of-order cycles may confuse the device; host then writes reset.
// R2: Device takes the address at the later falling edge of strobe or select.
// R3: Device takes the data at the earlier rising edge of strobe or select.
// R4: After power-up every bank reads array data without any command.
// R5: Finished program or erase returns the bank to array read.
// R6: Erase-suspend-read gives array data outside suspended sectors, status inside.
// R7: Reset command returns banks to read or erase-suspend-read; address ignored.
// R8: Reset aborts an unstarted erase sequence; ignored once erasure runs.
// R9: Reset aborts an unstarted program sequence; ignored once programming runs.
// R10: On the time-limit flag during program or erase the host writes reset.
// R11: Two unlocks then bank address with autoselect enter identification mode.
// R12: Autoselect only from read or suspend-read, never while other bank busy.
// R13: Identification mode is left only by reset, back to previous read mode.
// R14: Three cycles enter the secure region, four cycles leave it.
// R15: No secure access while busy; no bypass or acceleration inside secure region.
// R16: Word program is two unlocks, set-up, then address with data.
// R17: Commands during embedded program are ignored; completion seen by polling.
// R18: Hardware reset aborts programming; program again once bank reads array.
// R19: Programming cannot turn a 0 into a 1; only erase can.
// R20: Unlock bypass entry is two unlocks then 20h; bypass program is A0h, data.
// R21: Bypass mode accepts only bypass program and two-cycle bypass reset.
// R22: High voltage on the protect pin forces bypass; only for accelerated programming.
// R23: Erase suspend is B0h written with the bank address.
// R24: Unlock values and command codes are held as configurable constants.
module fbc_host
	import fbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output logic [FA_W-1:0] fl_addr,
	input wire logic [FD_W-1:0] fl_dq_in,
	output logic [FD_W-1:0] fl_dq_out,
	output logic fl_dq_oe_n,
	output logic fl_cs_n,
	output logic fl_we_n,
	output logic fl_oe_n,
	output logic fl_reset_n,
	input wire logic ready_busy_n,
	output logic accel_hv_en
);
	// ==========================================================
	// Command tables
	function automatic logic [1:0] seq_last(fbc_op_t op);
		case (op)
			OP_AUTOSEL, OP_SEC_ENTER, OP_BYP_ENTER: seq_last = 2'd2;
			OP_SEC_EXIT, OP_PROGRAM: seq_last = 2'd3;
			OP_BYP_PROG, OP_BYP_RESET: seq_last = 2'd1;
			default: seq_last = 2'd0;
		endcase
	endfunction

	function automatic logic [FA_W+FD_W-1:0] seq_word(fbc_op_t op, logic [1:0] s,
		logic [FA_W-1:0] a, logic [FD_W-1:0] d);
		logic [FA_W-1:0] bank;
		logic [FD_W-1:0] code;
		bank = {a[FA_W-1:BANK_LSB], UNL1_ADDR[BANK_LSB-1:0]};
		case (op)
			OP_AUTOSEL: code = CD_AUTOSEL;
			OP_SEC_ENTER: code = CD_SEC_ENTER;
			OP_SEC_EXIT: code = CD_SEC_EXIT;
			OP_PROGRAM: code = CD_PROGRAM;
			default: code = CD_BYP_ENTER;
		endcase
		case (op)
			OP_RESET: seq_word = {a, CD_RESET}; // [R7]
			OP_SUSPEND: seq_word = {a, CD_SUSPEND}; // [R23]
			OP_RESUME: seq_word = {a, CD_RESUME};
			OP_BYP_PROG: seq_word = (s == 2'd0) ? {a, CD_BYP_PROG} : {a, d}; // [R20]
			OP_BYP_RESET: seq_word = (s == 2'd0) ? {a, CD_BYP_RESET} : {a, CD_EXIT_TAIL}; // [R21]
			default:
			begin
				// Unlock, unlock, command, then optional fourth word. [R11] [R14] [R16] [R24]
				case (s)
					2'd0: seq_word = {UNL1_ADDR, UNL1_DATA};
					2'd1: seq_word = {UNL2_ADDR, UNL2_DATA};
					2'd2: seq_word = {(op == OP_AUTOSEL) ? bank : UNL1_ADDR, code};
					default: seq_word = (op == OP_PROGRAM) ? {a, d} : {a, CD_EXIT_TAIL};
				endcase
			end
		endcase
	endfunction

	function automatic logic op_legal(fbc_op_t op, fbc_mode_t m);
		case (op)
			OP_RESET: op_legal = (m != MD_BYPASS); // [R21]
			OP_AUTOSEL, OP_SUSPEND, OP_RESUME: op_legal = (m == MD_READ); // [R12]
			OP_SEC_ENTER, OP_BYP_ENTER: op_legal = (m == MD_READ); // [R15]
			OP_SEC_EXIT: op_legal = (m == MD_SECURE); // [R14]
			OP_PROGRAM: op_legal = (m == MD_READ) || (m == MD_SECURE);
			OP_BYP_PROG, OP_BYP_RESET: op_legal = (m == MD_BYPASS); // [R21]
			OP_READ, OP_HW_RESET: op_legal = 1'b1;
			default: op_legal = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// State
	fbc_state_t st_r;
	fbc_op_t op_r;
	fbc_mode_t mode_r;
	logic [1:0] step_r;
	logic [3:0] cnt_r;
	logic poll_r, susp_r, err_r, tlim_r, accel_en_r;
	logic [FA_W-1:0] addr_r, fl_addr_r;
	logic [FD_W-1:0] data_r, rdata_r, fl_dq_out_r;
	logic [31:0] sw_rdata_r;
	logic fl_dq_oe_n_r, fl_cs_n_r, fl_we_n_r, fl_oe_n_r, fl_reset_n_r, accel_hv_en_r;

	// ==========================================================
	// Decode
	wire fbc_op_t req_op = fbc_op_t'(sw_wdata[CMD_OP_LSB +: 4]);
	wire wr_cmd = sw_wr && (sw_addr == REG_CMD);
	wire wr_stat = sw_wr && (sw_addr == REG_STAT);
	wire idle = (st_r == ST_IDLE);
	wire go = wr_cmd && (req_op != OP_NONE) && idle && op_legal(req_op, mode_r);
	wire refuse = wr_cmd && (req_op != OP_NONE) && !go;
	wire wp_done = (cnt_r == 4'(WP_CYC));
	wire acc_done = (cnt_r == 4'(ACC_CYC));
	wire rp_done = (cnt_r == 4'(RP_CYC - 1));
	wire seq_end = (st_r == ST_WEND) && (step_r == seq_last(op_r));
	wire sample = (st_r == ST_RWAIT) && acc_done;
	wire prog_ok = ready_busy_n && (fl_dq_in[7] == data_r[7]);
	wire tlim_hit = sample && poll_r && !prog_ok && fl_dq_in[5];
	wire [7:0] status = {ready_busy_n, susp_r, 2'(mode_r), 1'b0, tlim_r, err_r, !idle};
	wire [31:0] rd_mux = (sw_addr == REG_CMD) ? {23'h0, accel_en_r, 4'h0, 4'(op_r)} :
		(sw_addr == REG_ADDR) ? 32'(addr_r) :
		(sw_addr == REG_DATA) ? data_r :
		(sw_addr == REG_STAT) ? {24'h0, status} :
		(sw_addr == REG_RDATA) ? rdata_r : 32'h0000_0000;

	// ==========================================================
	// Software registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			addr_r <= ADDR_RST;
			data_r <= DATA_RST;
			accel_en_r <= 1'b0;
			err_r <= 1'b0;
			tlim_r <= 1'b0;
			sw_rdata_r <= 32'h0000_0000;
			accel_hv_en_r <= 1'b0;
		end
		else if (ce)
		begin
			if (sw_wr && sw_addr == REG_ADDR && idle)
				addr_r <= sw_wdata[FA_W-1:0];
			if (sw_wr && sw_addr == REG_DATA && idle)
				data_r <= sw_wdata;
			if (wr_cmd)
				accel_en_r <= sw_wdata[CMD_ACC_BIT];
			// A refusal or a time-out arriving with the clear still sets the flag.
			err_r <= refuse || (err_r && !(wr_stat && sw_wdata[ST_ERR_BIT]));
			tlim_r <= tlim_hit || (tlim_r && !(wr_stat && sw_wdata[ST_TLIM_BIT]));
			sw_rdata_r <= sw_rd ? rd_mux : 32'h0000_0000;
			accel_hv_en_r <= accel_en_r && (mode_r == MD_BYPASS); // [R22] [R15]
		end
	end

	// ==========================================================
	// Bus cycle sequencer
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			op_r <= OP_NONE;
			mode_r <= MD_READ; // [R4]
			step_r <= 2'd0;
			cnt_r <= 4'h0;
			poll_r <= 1'b0;
			susp_r <= 1'b0;
			rdata_r <= DATA_RST;
			fl_addr_r <= ADDR_RST;
			fl_dq_out_r <= DATA_RST;
			fl_dq_oe_n_r <= 1'b1;
			fl_cs_n_r <= 1'b1;
			fl_we_n_r <= 1'b1;
			fl_oe_n_r <= 1'b1;
			fl_reset_n_r <= 1'b1;
		end
		else if (ce)
		begin
			case (st_r)
				ST_IDLE:
				begin
					cnt_r <= 4'h0;
					step_r <= 2'd0;
					if (go)
					begin
						op_r <= req_op;
						if (req_op == OP_READ)
							st_r <= ST_RSET;
						else if (req_op == OP_HW_RESET)
						begin
							fl_reset_n_r <= 1'b0; // [R18]
							st_r <= ST_HRST;
						end
						else
							st_r <= ST_WSET;
					end
				end
				ST_WSET:
				begin
					{fl_addr_r, fl_dq_out_r} <= seq_word(op_r, step_r, addr_r, data_r);
					fl_cs_n_r <= 1'b0;
					fl_dq_oe_n_r <= 1'b0;
					cnt_r <= 4'h0;
					st_r <= ST_WLOW;
				end
				ST_WLOW:
				begin
					// Strobe falls after select and address settle. [R2]
					cnt_r <= cnt_r + 4'h1;
					fl_we_n_r <= wp_done;
					if (wp_done)
						st_r <= ST_WEND;
				end
				ST_WEND:
				begin
					// Strobe rose first, so data is taken while still driven. [R3]
					fl_cs_n_r <= 1'b1;
					fl_dq_oe_n_r <= 1'b1;
					step_r <= step_r + 2'd1;
					st_r <= ST_WSET;
					if (seq_end)
					begin
						st_r <= ST_IDLE;
						case (op_r)
							OP_RESET, OP_SEC_EXIT, OP_BYP_RESET: mode_r <= MD_READ; // [R13] [R1]
							OP_AUTOSEL: mode_r <= MD_AUTO; // [R11]
							OP_SEC_ENTER: mode_r <= MD_SECURE; // [R14]
							OP_BYP_ENTER: mode_r <= MD_BYPASS; // [R20]
							OP_SUSPEND: susp_r <= 1'b1;
							OP_RESUME: susp_r <= 1'b0;
							default: ;
						endcase
						if (op_r == OP_PROGRAM || op_r == OP_BYP_PROG)
						begin
							poll_r <= 1'b1; // [R17]
							st_r <= ST_RSET;
						end
					end
				end
				ST_RSET:
				begin
					fl_addr_r <= addr_r;
					fl_cs_n_r <= 1'b0;
					fl_oe_n_r <= 1'b0;
					cnt_r <= 4'h0;
					st_r <= ST_RWAIT;
				end
				ST_RWAIT:
				begin
					cnt_r <= cnt_r + 4'h1;
					if (acc_done)
					begin
						rdata_r <= fl_dq_in;
						fl_cs_n_r <= 1'b1;
						fl_oe_n_r <= 1'b1;
						st_r <= ST_IDLE;
						if (poll_r && prog_ok)
							poll_r <= 1'b0; // [R5]
						else if (tlim_hit)
						begin
							poll_r <= 1'b0;
							op_r <= OP_RESET; // [R10]
							step_r <= 2'd0;
							st_r <= ST_WSET;
						end
						else if (poll_r)
							st_r <= ST_RSET;
					end
				end
				ST_HRST:
				begin
					cnt_r <= cnt_r + 4'h1;
					if (rp_done)
					begin
						fl_reset_n_r <= 1'b1;
						mode_r <= MD_READ;
						susp_r <= 1'b0;
						poll_r <= 1'b0;
						st_r <= ST_IDLE;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	assign sw_rdata = sw_rdata_r;
	assign fl_addr = fl_addr_r;
	assign fl_dq_out = fl_dq_out_r;
	assign fl_dq_oe_n = fl_dq_oe_n_r;
	assign fl_cs_n = fl_cs_n_r;
	assign fl_we_n = fl_we_n_r;
	assign fl_oe_n = fl_oe_n_r;
	assign fl_reset_n = fl_reset_n_r;
	assign accel_hv_en = accel_hv_en_r;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic [3:0] hr_cnt_r;
	always_ff @(posedge core_clk)
	begin
		if (rst || fl_reset_n_r)
			hr_cnt_r <= 4'h0;
		else if (ce)
			hr_cnt_r <= hr_cnt_r + 4'h1;
	end

	sequence s_tlim_seen;
		ce && tlim_hit;
	endsequence
	sequence s_reset_written;
		$rose(fl_we_n_r) && fl_dq_out_r == CD_RESET;
	endsequence

	AST_WE_INSIDE_CS: assert property (!fl_we_n_r |-> !fl_cs_n_r && !fl_dq_oe_n_r) // [R2]
		else $error("write strobe low outside select");
	AST_ADDR_STABLE: assert property (!fl_we_n_r && $past(!fl_we_n_r) |-> $stable(fl_addr_r)) // [R2]
		else $error("address moved during write strobe");
	AST_DATA_AT_RISE: assert property ($rose(fl_we_n_r) |-> !fl_cs_n_r && !fl_dq_oe_n_r) // [R3]
		else $error("data not driven when strobe rose");
	AST_READ_AFTER_RESET: assert property ($past(rst) |-> mode_r == MD_READ && fl_reset_n_r) // [R4]
		else $error("not in array read after reset");
	AST_HW_RESET_LEN: assert property ($rose(fl_reset_n_r) |-> hr_cnt_r == 4'(RP_CYC)) // [R18]
		else $error("hardware reset pulse length wrong");
	AST_AUTOSEL_FROM_READ: assert property (go && req_op == OP_AUTOSEL |-> mode_r == MD_READ) // [R12]
		else $error("autoselect issued outside read mode");
	AST_ACCEL_BYPASS: assert property (accel_hv_en_r |-> $past(mode_r) == MD_BYPASS) // [R22]
		else $error("acceleration outside bypass mode");
	AST_QUIET_WHILE_POLL: assert property (poll_r |-> fl_we_n_r && fl_dq_oe_n_r) // [R17]
		else $error("write issued while programming");
	AST_TLIM_RESET: assert property (s_tlim_seen |-> ##[1:20] s_reset_written) // [R10]
		else $error("no reset after time-limit flag");
	AST_NO_BYP_IN_SECURE: assert property (mode_r == MD_SECURE |-> !(go && req_op == OP_BYP_ENTER)) // [R15]
		else $error("bypass entered from secure region");
endmodule

// ---- rtl/fbc_pkg.sv ----
// Constants and types shared by the flash bank command controller.
package fbc_pkg;
	// ==========================================================
	// Widths and timing
	localparam int FA_W = 23;
	localparam int FD_W = 32;
	localparam int CLK_NS = 100;
	localparam int T_WP_NS = 35;
	localparam int T_ACC_NS = 120;
	localparam int T_RP_NS = 500;
	localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int BANK_LSB = 21;
	// ==========================================================
	// Software register map and fields
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_DATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ACC_BIT = 8;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam int ST_TLIM_BIT = 2;
	localparam int ST_MODE_LSB = 4;
	localparam int ST_SUSP_BIT = 6;
	localparam int ST_RDY_BIT = 7;
	localparam logic [FA_W-1:0] ADDR_RST = 23'h0000;
	localparam logic [FD_W-1:0] DATA_RST = 32'h0000_0000;
	// ==========================================================
	// Unlock cycles and command codes, both halves of the word
	localparam logic [FA_W-1:0] UNL1_ADDR = 23'h0555;
	localparam logic [FA_W-1:0] UNL2_ADDR = 23'h02AA;
	localparam logic [FD_W-1:0] UNL1_DATA = 32'h00AA_00AA;
	localparam logic [FD_W-1:0] UNL2_DATA = 32'h0055_0055;
	localparam logic [FD_W-1:0] CD_RESET = 32'h00F0_00F0;
	localparam logic [FD_W-1:0] CD_AUTOSEL = 32'h0090_0090;
	localparam logic [FD_W-1:0] CD_SEC_ENTER = 32'h0088_0088;
	localparam logic [FD_W-1:0] CD_SEC_EXIT = 32'h0090_0090;
	localparam logic [FD_W-1:0] CD_EXIT_TAIL = 32'h0000_0000;
	localparam logic [FD_W-1:0] CD_PROGRAM = 32'h00A0_00A0;
	localparam logic [FD_W-1:0] CD_BYP_ENTER = 32'h0020_0020;
	localparam logic [FD_W-1:0] CD_BYP_PROG = 32'h00A0_00A0;
	localparam logic [FD_W-1:0] CD_BYP_RESET = 32'h0090_0090;
	localparam logic [FD_W-1:0] CD_SUSPEND = 32'h00B0_00B0;
	localparam logic [FD_W-1:0] CD_RESUME = 32'h0030_0030;
	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		OP_NONE, OP_RESET, OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT, OP_PROGRAM,
		OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_RESET, OP_SUSPEND, OP_RESUME,
		OP_READ, OP_HW_RESET
	} fbc_op_t;
	typedef enum logic [1:0] {MD_READ, MD_AUTO, MD_SECURE, MD_BYPASS} fbc_mode_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_WSET, ST_WLOW, ST_WEND, ST_RSET, ST_RWAIT, ST_HRST
	} fbc_state_t;
endpackage

// ---- sim/fbc_flash_model.sv ----
// Behavioural multi-bank flash device that answers the controller.
module fbc_flash_model
	import fbc_pkg::*;
#(
	// All three words are arbitrary values.
	parameter logic [FD_W-1:0] ID_WORD = 32'h0012_0034,
	parameter logic [FD_W-1:0] SN_WORD = 32'h5A5A_0001,
	parameter logic [FD_W-1:0] SUSP_WORD = 32'h0000_0040
)
(
	input wire logic [FA_W-1:0] addr,
	input wire logic [FD_W-1:0] din,
	output logic [FD_W-1:0] dout,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic reset_n,
	input wire logic accel,
	input wire logic fail,
	output logic ready_busy_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [FD_W-1:0] mem [16];
	logic [FD_W-1:0] last = 32'h0000_0000;
	logic [FD_W-1:0] pd = 32'h0000_0000;
	logic [FA_W-1:0] a_lat;
	logic [3:0] pa;
	logic pnext = 1'b0;
	logic tlim = 1'b0;
	logic sus = 1'b0;
	logic [1:0] ss = 2'b00;
	int step = 0;
	int gen = 0;
	event go;
	fbc_mode_t md = MD_READ;
	initial
	begin
		ready_busy_n = 1'b1;
		dout = 32'hFFFF_FFFF;
		foreach (mem[i])
			mem[i] = 32'hFFFF_FFFF;
	end
	// ==========
	// Command decoding.
	task automatic to_read();
		md = MD_READ;
		step = 0;
		pnext = 1'b0;
		tlim = 1'b0;
		ready_busy_n = 1'b1;
		gen++;
	endtask
	task automatic take(input logic [FA_W-1:0] a, input logic [FD_W-1:0] d);
		if (!ready_busy_n && !tlim)
			return;
		if (pnext)
		begin
			pnext = 1'b0;
			pa = a[3:0];
			pd = d;
			ready_busy_n = 1'b0;
			->go;
		end
		else if (md == MD_BYPASS)
		begin
			if (d == CD_BYP_PROG) pnext = 1'b1;
			else if (d == CD_BYP_RESET) step = 9;
			else if (step == 9 && d == CD_EXIT_TAIL) to_read();
		end
		else if (d == CD_RESET) to_read();
		else if (d == CD_SUSPEND)
		begin
			sus = 1'b1;
			ss = a[3:2];
		end
		else if (d == CD_RESUME) sus = 1'b0;
		else if (step == 0 && a == UNL1_ADDR && d == UNL1_DATA) step = 1;
		else if (step == 1 && a == UNL2_ADDR && d == UNL2_DATA) step = 2;
		else if (step == 2)
		begin
			step = 0;
			if (d == CD_PROGRAM) pnext = 1'b1;
			else if (d == CD_SEC_ENTER) md = MD_SECURE;
			else if (md == MD_SECURE && d == CD_SEC_EXIT) step = 3;
			else if (d == CD_AUTOSEL) md = MD_AUTO;
			else if (d == CD_BYP_ENTER && md != MD_SECURE) md = MD_BYPASS;
		end
		else if (step == 3 && d == CD_EXIT_TAIL) to_read();
		else step = 0;
	endtask
	always @(negedge cs_n or negedge we_n)
		if (!cs_n && !we_n)
			a_lat = addr;
	always @(posedge we_n or posedge cs_n)
		if (cs_n != we_n)
			take(a_lat, din);
	always @go
	begin : prog
		int g;
		g = gen;
		#800;
		if (g == gen && fail) tlim = 1'b1;
		else if (g == gen)
		begin
			mem[pa] &= pd;
			ready_busy_n = 1'b1;
		end
	end
	always @(negedge reset_n)
	begin
		to_read();
		sus = 1'b0;
	end
	always @(posedge accel)
		if (md != MD_SECURE) md = MD_BYPASS;
	always @(cs_n, oe_n, addr, ready_busy_n, md, tlim, sus, ss)
		if (!cs_n && !oe_n)
		begin
			dout = 32'h0000_0000;
			if (!ready_busy_n)
			begin
				dout[7] = ~pd[7];
				dout[5] = tlim;
			end
			else if (md == MD_AUTO) dout = ID_WORD;
			else if (md == MD_SECURE) dout = SN_WORD;
			else if (sus && addr[3:2] == ss) dout = SUSP_WORD;
			else dout = mem[addr[3:0]];
			last = dout;
		end
		else
			dout = ~last;
endmodule

// ---- sim/fbc_host_test.sv ----
// Self-checking bench for the flash bank command controller.
module fbc_host_test
	import fbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID_W = 32'h0012_0034;
	localparam logic [31:0] SN_W = 32'h5A5A_0001;
	localparam logic [31:0] SUSP_W = 32'h0000_0040;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sw_addr = 8'h00;
	logic [31:0] sw_wdata = 32'h0000_0000;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic fail = 1'b0;
	logic [31:0] sw_rdata;
	logic [FA_W-1:0] fl_addr;
	logic [FD_W-1:0] fl_dq_in;
	logic [FD_W-1:0] fl_dq_out;
	logic fl_dq_oe_n, fl_cs_n, fl_we_n, fl_oe_n, fl_reset_n, ready_busy_n, accel_hv_en;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	fbc_host i_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
		.fl_addr(fl_addr), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
		.fl_dq_oe_n(fl_dq_oe_n), .fl_cs_n(fl_cs_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
		.fl_reset_n(fl_reset_n), .ready_busy_n(ready_busy_n), .accel_hv_en(accel_hv_en));
	fbc_flash_model #(.ID_WORD(ID_W), .SN_WORD(SN_W), .SUSP_WORD(SUSP_W)) i_flash (
		.addr(fl_addr),
		.din(fl_dq_out), .dout(fl_dq_in), .cs_n(fl_cs_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
		.reset_n(fl_reset_n), .accel(accel_hv_en), .fail(fail), .ready_busy_n(ready_busy_n));
	initial
		forever #50 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			wrap_up();
		end
	end
	// ==========
	// Bus and checking tasks.
	task automatic wrap_up();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(negedge core_clk);
		d = sw_rdata;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rdr(a, d);
		check(d, exp);
	endtask
	task automatic op(input logic [31:0] code);
		logic [31:0] s;
		wr(REG_CMD, code);
		s = 32'h0000_0001;
		for (int i = 0; i < 300 && s[ST_BUSY_BIT]; i++)
			rdr(REG_STAT, s);
	endtask
	task automatic prog(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
		wr(REG_ADDR, a);
		wr(REG_DATA, d);
		op(c);
	endtask
	task automatic rd_at(input logic [31:0] a, input logic [31:0] exp);
		wr(REG_ADDR, a);
		op(32'h0000_000B);
		reg_is(REG_RDATA, exp);
	endtask
	// ==========
	// Scenarios.
	task automatic t_basic();
		rd_at(32'h0000_0003, 32'hFFFF_FFFF);
		reg_is(REG_STAT, 32'h0000_0080);
		wr(REG_ADDR, 32'h0000_0005);
		wr(REG_DATA, 32'h1234_5678);
		reg_is(REG_ADDR, 32'h0000_0005);
		reg_is(REG_DATA, 32'h1234_5678);
		wr(REG_CMD, 32'h0000_0005);
		op(32'h0000_0001);
		reg_is(REG_STAT, 32'h0000_0082);
		wr(REG_STAT, 32'h0000_0002);
		rd_at(32'h0000_0005, 32'h1234_5678);
		prog(32'h0000_0005, 32'hFFFF_0000, 32'h0000_0005);
		rd_at(32'h0000_0005, 32'h1234_0000);
		reg_is(8'h20, 32'h0000_0000);
		$display("power-up and program test finished");
	endtask
	task automatic t_auto();
		op(32'h0000_0002);
		reg_is(REG_STAT, 32'h0000_0090);
		rd_at(32'h0000_0005, ID_W);
		op(32'h0000_0001);
		reg_is(REG_STAT, 32'h0000_0080);
		rd_at(32'h0000_0005, 32'h1234_0000);
		op(32'h0000_0009);
		reg_is(REG_STAT, 32'h0000_00C0);
		rd_at(32'h0000_0005, SUSP_W);
		rd_at(32'h0000_0003, 32'hFFFF_FFFF);
		op(32'h0000_000A);
		reg_is(REG_STAT, 32'h0000_0080);
		rd_at(32'h0000_0005, 32'h1234_0000);
		$display("identification test finished");
	endtask
	task automatic t_bypass();
		op(32'h0000_0106);
		reg_is(REG_STAT, 32'h0000_00B0);
		reg_is(REG_CMD, 32'h0000_0106);
		check({31'h0, accel_hv_en}, 32'h0000_0001);
		op(32'h0000_0105);
		reg_is(REG_STAT, 32'h0000_00B2);
		wr(REG_STAT, 32'h0000_0002);
		prog(32'h0000_0007, 32'h0000_00F0, 32'h0000_0107);
		op(32'h0000_0108);
		reg_is(REG_STAT, 32'h0000_0080);
		check({31'h0, accel_hv_en}, 32'h0000_0000);
		rd_at(32'h0000_0007, 32'h0000_00F0);
		$display("bypass test finished");
	endtask
	task automatic t_secure();
		op(32'h0000_0003);
		reg_is(REG_STAT, 32'h0000_00A0);
		op(32'h0000_0106);
		reg_is(REG_STAT, 32'h0000_00A2);
		check({31'h0, accel_hv_en}, 32'h0000_0000);
		wr(REG_STAT, 32'h0000_0002);
		rd_at(32'h0000_0003, SN_W);
		op(32'h0000_0004);
		reg_is(REG_STAT, 32'h0000_0080);
		rd_at(32'h0000_0003, 32'hFFFF_FFFF);
		$display("secure region test finished");
	endtask
	task automatic t_faults();
		fail = 1'b1;
		prog(32'h0000_0009, 32'h0000_0000, 32'h0000_0005);
		reg_is(REG_STAT, 32'h0000_0084);
		fail = 1'b0;
		wr(REG_STAT, 32'h0000_0004);
		rd_at(32'h0000_0009, 32'hFFFF_FFFF);
		op(32'h0000_0006);
		op(32'h0000_000C);
		reg_is(REG_STAT, 32'h0000_0080);
		prog(32'h0000_000B, 32'h5555_5555, 32'h0000_0005);
		rd_at(32'h0000_000B, 32'h5555_5555);
		$display("time-limit and hardware reset test finished");
	endtask
	initial
	begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_basic();
		t_auto();
		t_bypass();
		t_secure();
		t_faults();
		wrap_up();
	end
endmodule
